/* hdl/genlock_control_source_select.sv */
// Control-source selection for a genlock clock generator, with its serial register port.
// Assumes one 100 MHz core clock and pins asynchronous to it; the bus pull-up is external.
`timescale 1ns/1ps
`include "genlock_cfg.svh"
`default_nettype none

module genlock_control_source_select (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic refSelPin,
  input wire logic modePin,
  input wire logic refLost,
  output logic refSelect,
  output logic genlockMode,
  output logic freerunActive,
  output logic outputInit
);

  // --------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------
  genlock_pkg::pins_type raw, s1_r, s2_r, s3_r, pinF_r, pinF_nxt, pinP_r;
  assign raw = '{scl: sclIn, sda: sdaIn, refSelPin: refSelPin, modePin: modePin,
                 refLost: refLost};

  // Glitch guard: a level counts only once two late stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_filt
      assign pinF_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s2_r[gi] : pinF_r[gi];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      pinF_r <= '1;
      pinP_r <= '1;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pinF_r <= pinF_nxt;
      pinP_r <= pinF_r;
    end
  end

  logic sclRise, sclFall, busStart, busStop;
  assign sclRise = pinF_r.scl & ~pinP_r.scl;
  assign sclFall = ~pinF_r.scl & pinP_r.scl;
  assign busStart = pinF_r.scl & pinP_r.scl & pinP_r.sda & ~pinF_r.sda;
  assign busStop = pinF_r.scl & pinP_r.scl & ~pinP_r.sda & pinF_r.sda;

  // --------------------------------------------------
  // Serial register port
  // --------------------------------------------------
  genlock_pkg::bus_state_type state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt;
  logic [7:0] srcReg_r, srcReg_nxt, ovrReg_r, ovrReg_nxt, initReg_r, initReg_nxt;
  logic rw_r, rw_nxt, oe_r, oe_nxt;
  genlock_pkg::route_type route_r, route_nxt;

  function automatic logic [7:0] readReg(input logic [7:0] a, input logic [7:0] s,
                                         input logic [7:0] o, input logic [7:0] i,
                                         input genlock_pkg::route_type r);
    case (a)
      `GCS_OFF_SOURCE: readReg = s;
      `GCS_OFF_STATUS: readReg = {4'h0, r};
      `GCS_OFF_OVERRIDE: readReg = o;
      `GCS_OFF_INIT: readReg = i;
      default: readReg = 8'h00;
    endcase
  endfunction

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    oe_nxt = oe_r;
    srcReg_nxt = srcReg_r;
    ovrReg_nxt = ovrReg_r;
    initReg_nxt = initReg_r;
    if (sclRise) begin
      shift_nxt = {shift_r[6:0], pinF_r.sda};
      cnt_nxt = cnt_r + 4'h1;
    end
    if (busStart) begin
      state_nxt = genlock_pkg::BUS_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (busStop) begin
      state_nxt = genlock_pkg::BUS_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (state_r)
        genlock_pkg::BUS_ADDR: begin
          if (sclFall && cnt_r == `GCS_BITS_PER_BYTE) begin
            if (shift_r[7:1] == `GCS_DEV_ADDR) begin
              oe_nxt = 1'b1;
              rw_nxt = shift_r[0];
              state_nxt = genlock_pkg::BUS_ACK_ADDR;
            end else begin
              state_nxt = genlock_pkg::BUS_IDLE;
            end
          end
        end
        genlock_pkg::BUS_ACK_ADDR: begin
          if (sclFall) begin
            cnt_nxt = 4'h0;
            if (rw_r) begin
              tx_nxt = readReg(ptr_r, srcReg_r, ovrReg_r, initReg_r, route_r);
              oe_nxt = ~tx_nxt[7];
              state_nxt = genlock_pkg::BUS_READ;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = genlock_pkg::BUS_PTR;
            end
          end
        end
        genlock_pkg::BUS_PTR: begin
          if (sclFall && cnt_r == `GCS_BITS_PER_BYTE) begin
            ptr_nxt = shift_r;
            oe_nxt = 1'b1;
            state_nxt = genlock_pkg::BUS_ACK_DATA;
          end
        end
        genlock_pkg::BUS_ACK_DATA: begin
          if (sclFall) begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            state_nxt = genlock_pkg::BUS_WRITE;
          end
        end
        genlock_pkg::BUS_WRITE: begin
          if (sclFall && cnt_r == `GCS_BITS_PER_BYTE) begin
            case (ptr_r)
              `GCS_OFF_SOURCE: srcReg_nxt = shift_r;
              `GCS_OFF_OVERRIDE: ovrReg_nxt = shift_r;
              `GCS_OFF_INIT: initReg_nxt = shift_r;
              default: ;
            endcase
            ptr_nxt = ptr_r + 8'h01;
            oe_nxt = 1'b1;
            state_nxt = genlock_pkg::BUS_ACK_DATA;
          end
        end
        genlock_pkg::BUS_READ: begin
          if (sclFall) begin
            if (cnt_r == `GCS_BITS_PER_BYTE) begin
              oe_nxt = 1'b0;
              state_nxt = genlock_pkg::BUS_READ_ACK;
            end else begin
              oe_nxt = ~tx_r[3'(4'h7 - cnt_r)];
            end
          end
        end
        genlock_pkg::BUS_READ_ACK: begin
          if (sclRise) begin
            if (pinF_r.sda) begin
              state_nxt = genlock_pkg::BUS_IDLE;
            end else begin
              ptr_nxt = ptr_r + 8'h01;
            end
          end else if (sclFall) begin
            cnt_nxt = 4'h0;
            tx_nxt = readReg(ptr_r, srcReg_r, ovrReg_r, initReg_r, route_r);
            oe_nxt = ~tx_nxt[7];
            state_nxt = genlock_pkg::BUS_READ;
          end
        end
        default: begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------
  // Source routing
  // --------------------------------------------------
  logic repurpose, refByReg, modeByReg, wantGenlock, dropToFree;
  assign repurpose = ovrReg_r[`GCS_BIT_REPURPOSE];
  // Repurposed pin cannot select, so the register always does
  assign refByReg = srcReg_r[`GCS_BIT_REF_SRC] | repurpose;
  assign modeByReg = srcReg_r[`GCS_BIT_MODE_SRC];
  assign wantGenlock = modeByReg ? srcReg_r[`GCS_BIT_MODE_VAL] : pinF_r.modePin;
  assign dropToFree = ovrReg_r[`GCS_BIT_FALLBACK] & pinF_r.refLost;

  // Pure mux on live values: changing a source bit takes effect next edge
  always_comb begin
    route_nxt.refSelect = refByReg ? srcReg_r[`GCS_BIT_REF_VAL] : pinF_r.refSelPin;
    route_nxt.genlockMode = wantGenlock & ~dropToFree;
    route_nxt.freerunActive = ~(wantGenlock & ~dropToFree);
    route_nxt.outputInit = repurpose ? pinF_r.refSelPin
                                     : initReg_r[`GCS_BIT_INIT];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= genlock_pkg::BUS_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
      srcReg_r <= `GCS_RST_SOURCE;
      ovrReg_r <= `GCS_RST_OVERRIDE;
      initReg_r <= `GCS_RST_INIT;
      route_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      oe_r <= oe_nxt;
      srcReg_r <= srcReg_nxt;
      ovrReg_r <= ovrReg_nxt;
      initReg_r <= initReg_nxt;
      route_r <= route_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe = oe_r;
  assign refSelect = route_r.refSelect;
  assign genlockMode = route_r.genlockMode;
  assign freerunActive = route_r.freerunActive;
  assign outputInit = route_r.outputInit;

  // --------------------------------------------------
  // Checks
  // --------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ref_from_pin_a: assert property (
    (!srcReg_r[`GCS_BIT_REF_SRC] && !repurpose) |=> refSelect == $past(pinF_r.refSelPin))
    else $error("reference select not following pin");
  ref_from_reg_a: assert property (
    repurpose |=> refSelect == $past(srcReg_r[`GCS_BIT_REF_VAL]))
    else $error("repurposed pin still selects reference");
  init_from_pin_a: assert property (
    (repurpose && $rose(pinF_r.refSelPin)) |=> outputInit)
    else $error("repurposed pin does not raise init");
  init_reg_ignored_a: assert property (
    (repurpose && !pinF_r.refSelPin) [*2] |-> !outputInit)
    else $error("init register bit used while repurposed");
  mode_from_pin_a: assert property (
    (!modeByReg && !dropToFree) |=> genlockMode == $past(pinF_r.modePin))
    else $error("mode not following pin");
  freerun_on_loss_a: assert property (
    dropToFree |=> freerunActive && !genlockMode)
    else $error("no free run after reference loss");
  sequence srcFlip_s;
    $changed(srcReg_r[`GCS_BIT_REF_SRC]) && !repurpose;
  endsequence
  live_switch_a: assert property (
    srcFlip_s |=> refSelect == ($past(srcReg_r[`GCS_BIT_REF_SRC]) ? $past(srcReg_r[`GCS_BIT_REF_VAL])
                                                : $past(pinF_r.refSelPin)))
    else $error("source change not applied next cycle");

endmodule // genlock_control_source_select

`default_nettype wire

/* hdl/genlock_cfg.svh */
// Offsets, field positions, reset values and bus constants of the control-source block.
// Assumes inclusion by bare name from files under hdl/.
`ifndef GENLOCK_CFG_SVH
`define GENLOCK_CFG_SVH

// --------------------------------------------------
// Register offsets
// --------------------------------------------------
`define GCS_OFF_SOURCE 8'h00
`define GCS_OFF_STATUS 8'h01
`define GCS_OFF_OVERRIDE 8'h02
`define GCS_OFF_INIT 8'h0A

// --------------------------------------------------
// Field positions
// --------------------------------------------------
`define GCS_BIT_REF_SRC 0
`define GCS_BIT_MODE_SRC 1
`define GCS_BIT_REF_VAL 2
`define GCS_BIT_MODE_VAL 3
`define GCS_BIT_REPURPOSE 0
`define GCS_BIT_FALLBACK 1
`define GCS_BIT_INIT 0

// --------------------------------------------------
// Reset values
// --------------------------------------------------
`define GCS_RST_SOURCE 8'h03
`define GCS_RST_OVERRIDE 8'h02
`define GCS_RST_INIT 8'h00

// --------------------------------------------------
// Serial bus
// --------------------------------------------------
`define GCS_DEV_ADDR 7'h2D
`define GCS_BITS_PER_BYTE 4'h8

`endif

/* hdl/genlock_pkg.sv */
// Types shared by the control-source block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package genlock_pkg;

  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_PTR, BUS_ACK_DATA, BUS_WRITE, BUS_READ, BUS_READ_ACK
  } bus_state_type;

  // Pin order of the synchroniser vector
  typedef struct packed {
    logic scl;
    logic sda;
    logic refSelPin;
    logic modePin;
    logic refLost;
  } pins_type;

  // Routed results
  typedef struct packed {
    logic refSelect;
    logic genlockMode;
    logic freerunActive;
    logic outputInit;
  } route_type;

endpackage

`default_nettype wire

/* tb/i2c_host_model.sv */
// Two-wire bus host that reaches the register port.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`include "genlock_cfg.svh"
`default_nettype none
module i2c_host_model (
  input wire logic core_clk,
  output var logic scl,
  output var logic sdaLow,
  input wire logic sda
);
  // Above the 10 cycle phase floor, short for run time
  localparam int HALF = 12;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // ----
  // Bit level
  // ----
  // Data moves 2 cycles after the fall, never with it
  task automatic bitIo(input logic b, output logic r);
    hold(2);
    sdaLow = ~b;
    hold(HALF - 2);
    scl = 1'b1;
    hold(HALF / 2);
    r = sda;
    hold(HALF / 2);
    scl = 1'b0;
  endtask
  task automatic startCond(input logic rep);
    if (rep) begin
      hold(2);
      sdaLow = 1'b0;
      hold(HALF);
      scl = 1'b1;
      hold(HALF);
    end
    sdaLow = 1'b1;
    hold(HALF);
    scl = 1'b0;
  endtask
  task automatic stopCond();
    hold(2);
    sdaLow = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sdaLow = 1'b0;
    hold(HALF);
  endtask
  // ----
  // Byte level, MSB first
  // ----
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], q[i]);
    end
    bitIo(1'b1, a);
  endtask
  task automatic wrReg(input logic [7:0] p, input logic [7:0] d, output logic [2:0] a);
    logic [7:0] q;
    startCond(1'b0);
    xfer({`GCS_DEV_ADDR, 1'b0}, q, a[2]);
    xfer(p, q, a[1]);
    xfer(d, q, a[0]);
    stopCond();
  endtask
  // Read ends with a nack
  task automatic rdReg(input logic [7:0] p, output logic [7:0] d, output logic [2:0] a);
    logic [7:0] q;
    logic n;
    startCond(1'b0);
    xfer({`GCS_DEV_ADDR, 1'b0}, q, a[2]);
    xfer(p, q, a[1]);
    startCond(1'b1);
    xfer({`GCS_DEV_ADDR, 1'b1}, q, a[0]);
    xfer(8'hFF, d, n);
    stopCond();
  endtask
endmodule // i2c_host_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the control-source block.
// Assumes the host model drives the bus.
`timescale 1ns/1ps
`include "genlock_cfg.svh"
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic refSelPin = 1'b0;
  logic modePin = 1'b0;
  logic refLost = 1'b0;
  logic scl, sdaLow, sda, sdaOut, sdaOe, refSelect, genlockMode, freerunActive, outputInit;
  genlock_pkg::route_type got;
  int miscompares = 0;
  int n_tests = 0;
  logic [7:0] src, ovr, ini, q;
  logic [2:0] a;
  always #5 core_clk = ~core_clk;
  assign sda = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;
  assign got = {refSelect, genlockMode, freerunActive, outputInit};
  genlock_control_source_select genlock_control_source_select_inst (.core_clk, .rst_n,
    .sclIn(scl), .sdaIn(sda), .sdaOut, .sdaOe, .refSelPin, .modePin, .refLost, .refSelect,
    .genlockMode, .freerunActive, .outputInit);
  i2c_host_model i2c_host_model_inst (.core_clk, .scl, .sdaLow, .sda);
  // ----
  // Checks
  // ----
  function automatic genlock_pkg::route_type expRoute();
    logic r, g;
    r = (ovr[`GCS_BIT_REPURPOSE] | src[`GCS_BIT_REF_SRC]) ? src[`GCS_BIT_REF_VAL] : refSelPin;
    g = (src[`GCS_BIT_MODE_SRC] ? src[`GCS_BIT_MODE_VAL] : modePin)
        & ~(ovr[`GCS_BIT_FALLBACK] & refLost);
    return {r, g, ~g, ovr[`GCS_BIT_REPURPOSE] ? refSelPin : ini[`GCS_BIT_INIT]};
  endfunction
  task automatic cmpRoute();
    n_tests++;
    if (got !== expRoute()) begin
      miscompares++;
      $display("MISMATCH %0t route %b exp %b", $time, got, expRoute());
    end
  endtask
  task automatic cmpByte(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t byte %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i2c_host_model_inst.wrReg(p, d, a);
    cmpByte({5'h00, a}, 8'h00);
  endtask
  task automatic rdChk(input logic [7:0] p, input logic [7:0] e);
    i2c_host_model_inst.rdReg(p, q, a);
    cmpByte({5'h00, a}, 8'h00);
    cmpByte(q, e);
  endtask
  task automatic end_of_test();
    $display("Compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h6DD652B6));
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    src = `GCS_RST_SOURCE;
    ovr = `GCS_RST_OVERRIDE;
    ini = `GCS_RST_INIT;
    cmpRoute();
    rdChk(`GCS_OFF_SOURCE, src);
    rdChk(`GCS_OFF_OVERRIDE, ovr);
    rdChk(`GCS_OFF_INIT, ini);
    rdChk(8'h05, 8'h00);
    $display("Test reset done");
    src = 8'h04;
    ovr = 8'h01;
    ini = 8'h01;
    wr(`GCS_OFF_SOURCE, src);
    wr(`GCS_OFF_OVERRIDE, ovr);
    wr(`GCS_OFF_INIT, ini);
    for (int k = 0; k < 8; k++) begin
      {refSelPin, modePin, refLost} = 3'(k);
      repeat (10) @(negedge core_clk);
      cmpRoute();
    end
    i2c_host_model_inst.wrReg(`GCS_OFF_STATUS, 8'hFF, a);
    rdChk(`GCS_OFF_STATUS, {4'h0, expRoute()});
    $display("Test repurpose done");
    for (int i = 0; i < 16; i++) begin
      src = 8'($urandom_range(15));
      ovr = 8'($urandom_range(3));
      ini = 8'($urandom_range(1));
      wr(`GCS_OFF_SOURCE, src);
      wr(`GCS_OFF_OVERRIDE, ovr);
      wr(`GCS_OFF_INIT, ini);
      for (int j = 0; j < 4; j++) begin
        {refSelPin, modePin, refLost} = 3'($urandom());
        repeat (10) @(negedge core_clk);
        cmpRoute();
      end
      rdChk(`GCS_OFF_SOURCE, src);
    end
    $display("Test random done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
